// ### rtl/tps_defs.vh
`ifndef TPS_DEFS_VH
`define TPS_DEFS_VH

// ----------------------------------------------------------------
// Test point strap configuration constants
// ----------------------------------------------------------------

`define TPS_PIN_W          8
`define TPS_STRAP_RST      8'h00
`define TPS_MODE_QUIET     3'h0
`define TPS_MODE_CLKDBG    3'h2

// Output source select codes (4 bits per pin)
`define TPS_SEL_W          4
`define TPS_SEL_HIZ        4'h0
`define TPS_SEL_LOW        4'h1
`define TPS_SEL_HIGH       4'h2
`define TPS_SEL_CLK60      4'h3
`define TPS_SEL_CLK30      4'h4
`define TPS_SEL_CLKVAR     4'h5
`define TPS_SEL_CLK7P5     4'h6

// Debug clock frequencies in kHz, core clock in kHz
`define TPS_CORE_KHZ       250000
`define TPS_CLK60_KHZ      60000
`define TPS_CLK30_KHZ      30000
`define TPS_CLK7P5_KHZ     7500

// Half-period counts in core cycles, rounded down, at least one
`define TPS_HALF_W         8
`define TPS_HALF60   (((`TPS_CORE_KHZ / (2 * `TPS_CLK60_KHZ)) < 1) ? 1 : (`TPS_CORE_KHZ / (2 * `TPS_CLK60_KHZ)))
`define TPS_HALF30   (((`TPS_CORE_KHZ / (2 * `TPS_CLK30_KHZ)) < 1) ? 1 : (`TPS_CORE_KHZ / (2 * `TPS_CLK30_KHZ)))
`define TPS_HALF7P5  (((`TPS_CORE_KHZ / (2 * `TPS_CLK7P5_KHZ)) < 1) ? 1 : (`TPS_CORE_KHZ / (2 * `TPS_CLK7P5_KHZ)))
`define TPS_VAR_RST        8'h05

`endif

// ### rtl/tps_test_point.v
`timescale 1ns/1ps
`include "tps_defs.vh"
// Behaviour
// RULE1: Pins stay inputs, undriven, while system reset is held low.
// RULE2: After reset release the pins switch to output operation.
// RULE3: Capture pin levels at release; hold mode until next reset.
// RULE4: Straps sampled only on reset rising edge; later changes ignored.
// RULE5: Every pin has an internal pulldown so open pins read zero.
// RULE6: Strap code 000 keeps all outputs tri-stated.
// RULE7: Code 010 drives 60 MHz pin 0, 30 MHz pin 1, variable pin 2; the 250 MHz core gives 62.5 and 31.25 MHz instead.
// RULE8: Clock debug mode drives pins 3,5,6 high, 4 low, 7.5 MHz pin 7; pin 7 runs at 7.8125 MHz here.
// RULE9: Software may change each pin's signal selection at any time; writes before the default load are ignored.
// RULE10: Board selects other modes with jumpered pullups on low three pins.
// RULE11: Board leaves upper five pins unconnected with no pullups.
// RULE12: Other strap codes behave like the default tri-state mode.
module tps_test_point (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Test point pins
  input  wire [7:0]  test_point_pins_in,
  output reg  [7:0]  test_point_pins_out,
  output reg  [7:0]  test_point_pins_oe,
  output wire [7:0]  test_point_pins_pulldown,
  // Software selection override
  input  wire        sel_wr,
  input  wire [2:0]  sel_pin,
  input  wire [3:0]  sel_code,
  input  wire [7:0]  var_half,
  // Status
  output reg  [7:0]  strap_value,
  output reg         strap_valid
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------

  // Pulldowns always enabled; weak, so straps still win
  // Enables only; the resistors themselves sit in the pad ring
  assign test_point_pins_pulldown = 8'hFF; // RULE5

  // Pin synchroniser and release tracker state
  reg  [7:0] pin_meta;
  reg  [7:0] pin_sync;
  reg        rel_q1;
  reg        rel_q2;

  // Two-stage sync of pin levels; reset-free so it keeps sampling
  // while nrst is low, giving the level present at release
  always @(posedge clk) begin
    pin_meta <= test_point_pins_in;
    pin_sync <= pin_meta;
  end

  // Release tracker: flags the first edges after nrst rises
  // q1 marks the capture edge, q2 the default load edge after it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_q1 <= 1'b0;
      rel_q2 <= 1'b0;
    end else begin
      rel_q1 <= 1'b1;
      rel_q2 <= rel_q1;
    end
  end

  // Latch once at the release edge only; pins are still undriven then
  // A strap moving inside the sync window may be caught mid-change
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_value <= `TPS_STRAP_RST;
      strap_valid <= 1'b0;
    end else if (!rel_q1) begin
      strap_value <= pin_sync; // RULE3 RULE4
      strap_valid <= 1'b1;     // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Debug clock generators
  // ----------------------------------------------------------------

  // Divider counters, toggled clock levels and variable limit
  reg  [7:0] cnt60;
  reg  [7:0] cnt30;
  reg  [7:0] cnt7;
  reg  [7:0] cntv;
  reg        clk60;
  reg        clk30;
  reg        clk7;
  reg        clkv;
  reg  [7:0] var_lim;

  // Divider step shared by every debug clock
  function [8:0] div_step;
    input [7:0] cnt;
    input [7:0] half;
    begin
      if (cnt >= half - 8'h01)
        div_step = {1'b1, 8'h00};
      else
        div_step = {1'b0, cnt + 8'h01};
    end
  endfunction

  // Half periods kept 32 bits wide, then cut to the 8-bit divider limit
  localparam [31:0] HALF60_F  = `TPS_HALF60;
  localparam [31:0] HALF30_F  = `TPS_HALF30;
  localparam [31:0] HALF7P5_F = `TPS_HALF7P5;

  // Next count and toggle flag per divider
  wire [8:0] s60 = div_step(cnt60, HALF60_F[7:0]);
  wire [8:0] s30 = div_step(cnt30, HALF30_F[7:0]);
  wire [8:0] s7  = div_step(cnt7, HALF7P5_F[7:0]);
  wire [8:0] sv  = div_step(cntv, var_lim);

  // 250 MHz core cannot give exact 60/30 MHz; the next faster rate is used
  // A variable limit of zero would wrap the compare to 255, so it is forced to one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt60   <= 8'h00;
      cnt30   <= 8'h00;
      cnt7    <= 8'h00;
      cntv    <= 8'h00;
      clk60   <= 1'b0;
      clk30   <= 1'b0;
      clk7    <= 1'b0;
      clkv    <= 1'b0;
      var_lim <= `TPS_VAR_RST;
    end else begin
      cnt60 <= s60[7:0];
      cnt30 <= s30[7:0];
      cnt7  <= s7[7:0];
      cntv  <= sv[7:0];
      clk60 <= clk60 ^ s60[8];
      clk30 <= clk30 ^ s30[8];
      clk7  <= clk7 ^ s7[8];
      clkv  <= clkv ^ sv[8];
      var_lim <= (var_half == 8'h00) ? 8'h01 : var_half;
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------

  // Per-pin source selection and its load state
  reg  [3:0] sel [0:7];
  reg        loaded;
  integer    i;
  integer    j;

  // Default per strap mode, applied once after capture
  function [3:0] dflt_sel;
    input [2:0] mode;
    input [2:0] pin;
    begin
      if (mode == `TPS_MODE_CLKDBG) begin
        case (pin)
          3'h0:    dflt_sel = `TPS_SEL_CLK60;  // RULE7
          3'h1:    dflt_sel = `TPS_SEL_CLK30;  // RULE7
          3'h2:    dflt_sel = `TPS_SEL_CLKVAR; // RULE7
          3'h4:    dflt_sel = `TPS_SEL_LOW;    // RULE8
          3'h7:    dflt_sel = `TPS_SEL_CLK7P5; // RULE8
          default: dflt_sel = `TPS_SEL_HIGH;   // RULE8
        endcase
      end else begin
        dflt_sel = `TPS_SEL_HIZ; // RULE6 RULE12
      end
    end
  endfunction

  // Software write wins over the default load only after it is done
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loaded <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        sel[i] <= `TPS_SEL_HIZ;
    end else if (rel_q1 && !rel_q2) begin
      loaded <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
        sel[i] <= dflt_sel(strap_value[2:0], i[2:0]);
    end else if (loaded && sel_wr) begin
      sel[sel_pin] <= sel_code; // RULE9
    end
  end

  // Combinational pin level and enable ahead of the output flops
  reg [7:0] next_out;
  reg [7:0] next_oe;

  // Decode selection to pin level and drive enable
  always @* begin
    next_out = 8'h00;
    next_oe  = 8'h00;
    for (j = 0; j < 8; j = j + 1) begin
      next_oe[j] = (sel[j] != `TPS_SEL_HIZ);
      // Undefined codes still drive, at a low level
      case (sel[j])
        `TPS_SEL_HIGH:   next_out[j] = 1'b1;
        `TPS_SEL_CLK60:  next_out[j] = clk60;
        `TPS_SEL_CLK30:  next_out[j] = clk30;
        `TPS_SEL_CLKVAR: next_out[j] = clkv;
        `TPS_SEL_CLK7P5: next_out[j] = clk7;
        default:         next_out[j] = 1'b0;
      endcase
    end
  end

  // Drivers held off until release and selections loaded
  // Registered so every pin changes on the same clock edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      test_point_pins_out <= 8'h00;
      test_point_pins_oe  <= 8'h00; // RULE1
    end else begin
      test_point_pins_out <= next_out;
      test_point_pins_oe  <= loaded ? next_oe : 8'h00; // RULE2
    end
  end

endmodule // tps_test_point

// ### tb/tps_test_point_properties.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module tps_test_point_properties (
  // Clock and reset
  input wire       clk,
  input wire       nrst,
  // Pins and selection
  input wire [7:0] test_point_pins_out,
  input wire [7:0] test_point_pins_oe,
  input wire [7:0] test_point_pins_pulldown,
  input wire       sel_wr,
  input wire [2:0] sel_pin,
  input wire [3:0] sel_code,
  // Status
  input wire [7:0] strap_value,
  input wire       strap_valid
);
  wire [7:0] oe = test_point_pins_oe;
  wire [7:0] q = test_point_pins_out;
  wire       dbg = strap_value[2:0] == 3'h2;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Reset check must not be masked by reset itself
  property p_rst; disable iff (1'b0) !nrst |-> oe == 8'h00 && !strap_valid; endproperty
  a_rst: assert property (p_rst) else $error("pins driven in reset");
  property p_hold; strap_valid |=> strap_valid && $stable(strap_value); endproperty
  a_hold: assert property (p_hold) else $error("strap value moved");
  property p_pd; test_point_pins_pulldown == 8'hFF; endproperty
  a_pd: assert property (p_pd) else $error("pulldown off");
  property p_quiet; $rose(strap_valid) && !dbg |-> ##2 (oe == 8'h00) [*4]; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet mode drives");
  property p_dbg; $rose(strap_valid) && dbg |-> ##2 oe == 8'hFF && q[6:3] == 4'hD; endproperty
  a_dbg: assert property (p_dbg) else $error("debug levels wrong");
  // Pin 0 is never reselected by the bench, so its rate stays fixed
  property p_c60; dbg && oe[0] && $past(oe[0]) && $changed(q[0]) |=> $stable(q[0]) ##1 $changed(q[0]); endproperty
  a_c60: assert property (p_c60) else $error("pin 0 rate wrong");
  property p_sw; $past(sel_wr, 2) && $past(sel_code, 2) == 4'h1 |-> oe[$past(sel_pin, 2)] && !q[$past(sel_pin, 2)];
  endproperty
  a_sw: assert property (p_sw) else $error("selection not applied");
  property p_late; $past(sel_wr) && $past(strap_valid) |-> $stable(strap_value); endproperty
  a_late: assert property (p_late) else $error("strap changed by write");
endmodule // tps_test_point_properties

bind tps_test_point tps_test_point_properties chk_u (.clk, .nrst, .test_point_pins_out, .test_point_pins_oe,
  .test_point_pins_pulldown, .sel_wr, .sel_pin, .sel_code, .strap_value, .strap_valid);

// ### tb/tps_board.sv
`timescale 1ns/1ps
// ----
// Board straps
// ----
module tps_board (
  // Jumpers on low pins only
  input  wire [2:0] strap_pu,
  // Device side
  input  wire [7:0] oe,
  input  wire [7:0] drv,
  input  wire [7:0] pd,
  // Resolved level
  output wire [7:0] pin
);
  // An unpulled open pin reads high, so a lost pulldown shows up
  assign pin = (oe & drv) | (~oe & ({5'h00, strap_pu} | ~pd));
endmodule // tps_board

// ### tb/tps_test_point_tb_top.sv
`timescale 1ns/1ps
module tps_test_point_tb_top;
  // ----
  // Bench
  // ----
  reg        clk = 0;
  reg        nrst = 0;
  reg  [2:0] strap_pu = 0;
  reg        sel_wr = 0;
  reg  [2:0] sel_pin = 0;
  reg  [3:0] sel_code = 0;
  reg  [7:0] var_half = 8'h04;
  reg  [7:0] c0, c1, c2, c7, pv;
  wire [7:0] pin, drv, oe, pd, sv;
  wire       svld;
  integer    err_count = 0;
  integer    n_tests = 0;
  integer    i, k;
  always #2 clk = ~clk;
  tps_test_point dut_u (.clk(clk), .nrst(nrst), .test_point_pins_in(pin), .test_point_pins_out(drv),
    .test_point_pins_oe(oe), .test_point_pins_pulldown(pd), .sel_wr(sel_wr), .sel_pin(sel_pin),
    .sel_code(sel_code), .var_half(var_half), .strap_value(sv), .strap_valid(svld));
  tps_board board_u (.strap_pu(strap_pu), .oe(oe), .drv(drv), .pd(pd), .pin(pin));
  task chk(input [31:0] got, input [31:0] exp); begin
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task stop_test; begin
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  // Straps stay put 4 cycles around release, past the pin synchroniser
  task strap_run(input [2:0] code); begin
    nrst = 0;
    strap_pu = code;
    repeat (4) @(negedge clk);
    chk(oe, 8'h00);
    nrst = 1;
    i = 0;
    while (svld !== 1'b1 && i < 8) begin
      @(negedge clk);
      i = i + 1;
    end
    if (i == 8) begin
      err_count = err_count + 1;
      stop_test;
    end
    chk(sv, {5'h00, code});
    repeat (3) @(negedge clk);
  end endtask
  task quiet_mode(input [2:0] code); begin
    strap_run(code);
    chk(oe, 8'h00);
    strap_pu = 3'h2;
    repeat (4) @(negedge clk);
    chk({sv, oe}, {5'h00, code, 8'h00});
  end endtask
  // Count toggles over 32 cycles; whole half periods make it phase free
  task clock_mode; begin
    strap_run(3'h2);
    chk({oe, drv[6:3]}, {8'hFF, 4'hD});
    {c0, c1, c2, c7} = 0;
    for (i = 0; i < 32; i = i + 1) begin
      pv = drv;
      @(negedge clk);
      c0 = c0 + (pv[0] ^ drv[0]);
      c1 = c1 + (pv[1] ^ drv[1]);
      c2 = c2 + (pv[2] ^ drv[2]);
      c7 = c7 + (pv[7] ^ drv[7]);
    end
    chk({c0, c1, c2, c7}, {8'h10, 8'h08, 8'h08, 8'h02});
  end endtask
  // Back to back writes on pins 3, 5 and 6
  task sw_select; begin
    sel_wr = 1;
    sel_pin = 3'h3;
    sel_code = 4'h1;
    @(negedge clk);
    sel_pin = 3'h5;
    sel_code = 4'h0;
    @(negedge clk);
    sel_pin = 3'h6;
    sel_code = 4'hF;
    @(negedge clk);
    sel_wr = 0;
    repeat (2) @(negedge clk);
    chk({oe[6:3], drv[6], drv[3]}, 6'h2C);
  end endtask
  initial begin
    for (k = 0; k < 8; k = k + 1) if (k != 2) quiet_mode(k[2:0]);
    clock_mode;
    sw_select;
    stop_test;
  end
endmodule // tps_test_point_tb_top
